// >>> design/pwlnc_pkg.sv
package pwlnc_pkg;
	localparam logic [7:0] CMD_OPERATION  = 8'h01;
	localparam logic [7:0] CMD_ON_OFF     = 8'h02;
	localparam logic [7:0] CMD_CLEAR      = 8'h03;
	localparam logic [7:0] CMD_WRITE_LOCK = 8'h10;
	localparam logic [7:0] CMD_STORE      = 8'h11;
	localparam logic [7:0] CMD_RESTORE    = 8'h12;
	localparam logic [7:0] CMD_FEATURES   = 8'h19;
	localparam logic [7:0] CMD_ALERT_MASK = 8'h1B;
	localparam logic [7:0] CMD_VOUT       = 8'h21;
	localparam logic [7:0] CMD_STAT_BYTE  = 8'h78;
	localparam logic [7:0] CMD_STAT_WORD  = 8'h79;
	localparam logic [7:0] CMD_STAT_CML   = 8'h7E;
	localparam logic [7:0] CMD_STAT_MFR   = 8'h80;

	localparam logic [7:0] LOCK_ALL        = 8'h80;
	localparam logic [7:0] LOCK_OPER       = 8'h40;
	localparam logic [7:0] LOCK_CTRL       = 8'h20;
	localparam logic [7:0] LOCK_FIELD_MASK = 8'hE0;

	// pec 7, speed field 6:5 = 01 (400 kHz), alert protocol 4, low nibble 0
	localparam logic [7:0] FEATURES_VALUE  = 8'hB0;

	localparam logic [7:0] STAT_BYTE_CML   = 8'h02;
	localparam logic [7:0] CML_IVD         = 8'h40;
	localparam logic [7:0] CML_MEM         = 8'h10;
	localparam logic [7:0] BLOCK_COUNT_ONE = 8'h01;

	localparam int         NSTAT    = 7;
	localparam int         IDX_WORD = 0;
	localparam int         IDX_CML  = 5;
	localparam logic [2:0] IDX_W3   = 3'h0;
	localparam logic [2:0] IDX_MFR  = 3'h6;

	localparam logic [7:0]  OPER_RESET   = 8'h00;
	localparam logic [7:0]  ON_OFF_RESET = 8'h16;
	localparam logic [15:0] VOUT_RESET   = 16'h0000;

	localparam int T_BUSY_MS   = 100;
	localparam int MCLK_KHZ    = 25_000;
	localparam int BUSY_CYCLES = T_BUSY_MS * MCLK_KHZ;

	typedef struct packed {
		logic [7:0]             lock;
		logic [7:0]             oper;
		logic [7:0]             on_off;
		logic [15:0]            vout;
		logic [NSTAT-1:0][7:0]  mask;
	} pwlnc_image_t;

	typedef enum {SL_IDLE, SL_ADDR, SL_AACK, SL_RX, SL_RACK, SL_TX,
		SL_TACK} pwlnc_slave_t;
	typedef enum {NV_BOOT, NV_IDLE, NV_STORE, NV_RESTORE} pwlnc_nvm_t;
endpackage

// >>> design/pwlnc_core.sv
`timescale 1ns/100ps
// Overview of operation
// - every supported register reads back under any lock
// - restore leaves lock-protected operation, on/off and vout untouched
// - lock register is part of stored image
// - lock-all level refuses all but lock writes
// - operation level also allows operation writes
// - control level adds on/off and vout writes
// - multiple lock bits raise alert and cml
// - invalid lock setting means no protection
// - store copies storable settings into nonvolatile memory
// - store accepted while switching; faults ignored meanwhile
// - bus unresponsive about 100 ms after store/restore
// - programming failure nacks, sets cml and mem
// - restore reloads lock and mask always, other registers only if unprotected
// - restore stops switching and forces restart
// - user store/restore share codes and hardware
// - device_feature_flags byte reports pec, 400k, alert
// - alert mask blocks chosen conditions from alert
// - clear faults clears all; present faults reassert
module pwlnc_core
	import pwlnc_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = 7'h10,
	parameter int         BUSY_CYC   = BUSY_CYCLES
) (
	input  wire logic                   i_mclk,
	input  wire logic                   i_reset_n,
	input  wire logic                   i_scl,
	input  wire logic                   i_sda,
	input  wire logic [NSTAT-1:0][7:0]  i_fault_src,
	input  wire logic                   i_nvm_done,
	input  wire logic                   i_nvm_fail,
	input  wire pwlnc_image_t           i_nvm_image,
	output logic                        o_sda_out,
	output logic                        o_sda_oe,
	output logic                        o_smbalert_out,
	output logic                        o_smbalert_oe,
	output logic                        o_nvm_store,
	output logic                        o_nvm_restore,
	output pwlnc_image_t                o_nvm_image,
	output logic                        o_fault_ignore,
	output logic                        o_switch_stop,
	output pwlnc_image_t                o_settings
);
	localparam int BW = $clog2(BUSY_CYC + 1);

	function automatic logic lock_valid(input logic [7:0] l);
		return $countones(l & LOCK_FIELD_MASK) <= 1;
	endfunction

	// an invalid level applies no protection at all
	function automatic logic wr_ok(input logic [7:0] c, input logic [7:0] l);
		logic [7:0] e;
		e = lock_valid(l) ? l : 8'h00;
		if (c == CMD_WRITE_LOCK)
			return 1'b1;
		if (e[7])
			return 1'b0;
		if (e[6])
			return c == CMD_OPERATION;
		if (e[5])
			return c == CMD_OPERATION || c == CMD_ON_OFF
				|| c == CMD_VOUT;
		return 1'b1;
	endfunction

	function automatic logic code_ok(input logic [7:0] c);
		return (c >= CMD_STAT_WORD && c <= CMD_STAT_CML)
			|| c == CMD_STAT_MFR;
	endfunction

	function automatic logic [2:0] code_idx(input logic [7:0] c);
		logic [7:0] d;
		d = c - CMD_STAT_WORD;
		if (c == CMD_STAT_MFR || c == CMD_STAT_BYTE)
			return (c == CMD_STAT_MFR) ? IDX_MFR : IDX_W3;
		return d[2:0];
	endfunction

	logic [2:0]             scl_s, sda_s;
	pwlnc_slave_t           st_r, st_nxt;
	logic [3:0]             bit_r, bit_nxt;
	logic [7:0]             sh_r, sh_nxt, cmd_r, cmd_nxt;
	logic [1:0]             byte_r, byte_nxt;
	logic [1:0][7:0]        d_r, d_nxt;
	logic [7:0]             txi_r, txi_nxt;
	logic                   rw_r, rw_nxt, wact_r, wact_nxt;
	logic                   oe_r, oe_nxt, nack_r, nack_nxt;
	logic                   commit, nack_set, busy;
	logic [7:0]             rb;
	pwlnc_nvm_t             nv_r, nv_nxt;
	logic [BW-1:0]          cnt_r, cnt_nxt;
	logic [7:0]             lock_r, lock_nxt, oper_r, oper_nxt;
	logic [7:0]             onoff_r, onoff_nxt;
	logic [15:0]            vout_r, vout_nxt;
	logic [NSTAT-1:0][7:0]  mask_r, mask_nxt, stat_r, stat_nxt, set_v;
	logic                   alert_r, alert_nxt, clear_v;
	logic                   store_p, restore_p;

	// read path never looks at the lock level
	function automatic logic [7:0] rd_byte(input logic [7:0] c,
		input logic [7:0] aux, input logic [7:0] i);
		case (c)
		CMD_WRITE_LOCK: return lock_r;
		CMD_OPERATION:  return oper_r;
		CMD_ON_OFF:     return onoff_r;
		CMD_VOUT:       return (i == 8'h00) ? vout_r[7:0] : vout_r[15:8];
		CMD_FEATURES:   return FEATURES_VALUE;
		CMD_ALERT_MASK: return (i == 8'h00) ? BLOCK_COUNT_ONE
			: (code_ok(aux) ? mask_r[code_idx(aux)] : 8'h00);
		default:        return (code_ok(c) || c == CMD_STAT_BYTE)
			&& i == 8'h00 ? stat_r[code_idx(c)] : 8'h00;
		endcase
	endfunction

	wire start = scl_s[2] & scl_s[1] & sda_s[2] & ~sda_s[1];
	wire stop  = scl_s[2] & scl_s[1] & ~sda_s[2] & sda_s[1];
	wire rise  = scl_s[1] & ~scl_s[2];
	wire fall  = ~scl_s[1] & scl_s[2];

	assign busy = (cnt_r != '0) || (nv_r != NV_IDLE);

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
		end else begin
			scl_s <= {scl_s[1:0], i_scl};
			sda_s <= {sda_s[1:0], i_sda};
		end
	end

	always_comb begin
		st_nxt = st_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		cmd_nxt = cmd_r;
		byte_nxt = byte_r;
		d_nxt = d_r;
		txi_nxt = txi_r;
		rw_nxt = rw_r;
		wact_nxt = wact_r;
		oe_nxt = oe_r;
		nack_nxt = nack_r | nack_set;
		commit = 1'b0;
		rb = rd_byte(cmd_r, d_r[0], txi_r);
		if (start) begin
			st_nxt = SL_ADDR;
			bit_nxt = 4'h0;
			byte_nxt = 2'h0;
			txi_nxt = 8'h00;
			oe_nxt = 1'b0;
			wact_nxt = 1'b0;
		end else if (stop) begin
			st_nxt = SL_IDLE;
			oe_nxt = 1'b0;
			commit = wact_r;
			wact_nxt = 1'b0;
		end else begin
			case (st_r)
			SL_IDLE: ;
			SL_ADDR: begin
				if (rise && bit_r < 4'h8) begin
					sh_nxt = {sh_r[6:0], sda_s[1]};
					bit_nxt = bit_r + 4'h1;
				end else if (fall && bit_r == 4'h8) begin
					st_nxt = SL_IDLE;
					if (sh_r[7:1] == SLAVE_ADDR) begin
						if (busy) begin
							st_nxt = SL_IDLE;
						end else if (nack_r) begin
							nack_nxt = 1'b0;
						end else begin
							st_nxt = SL_AACK;
							oe_nxt = 1'b1;
							rw_nxt = sh_r[0];
						end
					end
				end
			end
			SL_AACK: if (fall) begin
				bit_nxt = 4'h0;
				if (rw_r) begin
					sh_nxt = rb;
					oe_nxt = ~rb[7];
					txi_nxt = txi_r + 8'h01;
					st_nxt = SL_TX;
				end else begin
					oe_nxt = 1'b0;
					wact_nxt = 1'b1;
					st_nxt = SL_RX;
				end
			end
			SL_RX: begin
				if (rise && bit_r < 4'h8) begin
					sh_nxt = {sh_r[6:0], sda_s[1]};
					bit_nxt = bit_r + 4'h1;
				end else if (fall && bit_r == 4'h8) begin
					oe_nxt = 1'b1;
					st_nxt = SL_RACK;
					if (byte_r == 2'h0)
						cmd_nxt = sh_r;
					else if (byte_r != 2'h3)
						d_nxt[byte_r - 2'h1] = sh_r;
					if (byte_r != 2'h3)
						byte_nxt = byte_r + 2'h1;
				end
			end
			SL_RACK: if (fall) begin
				oe_nxt = 1'b0;
				bit_nxt = 4'h0;
				st_nxt = SL_RX;
			end
			SL_TX: if (fall) begin
				if (bit_r == 4'h7) begin
					oe_nxt = 1'b0;
					st_nxt = SL_TACK;
				end else begin
					sh_nxt = {sh_r[6:0], 1'b0};
					oe_nxt = ~sh_r[6];
					bit_nxt = bit_r + 4'h1;
				end
			end
			SL_TACK: begin
				if (rise && sda_s[1]) begin
					st_nxt = SL_IDLE;
				end else if (fall) begin
					sh_nxt = rb;
					oe_nxt = ~rb[7];
					txi_nxt = txi_r + 8'h01;
					bit_nxt = 4'h0;
					st_nxt = SL_TX;
				end
			end
			default: st_nxt = SL_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r <= SL_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			cmd_r <= 8'h00;
			byte_r <= 2'h0;
			d_r <= '0;
			txi_r <= 8'h00;
			rw_r <= 1'b0;
			wact_r <= 1'b0;
			oe_r <= 1'b0;
			nack_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			cmd_r <= cmd_nxt;
			byte_r <= byte_nxt;
			d_r <= d_nxt;
			txi_r <= txi_nxt;
			rw_r <= rw_nxt;
			wact_r <= wact_nxt;
			oe_r <= oe_nxt;
			nack_r <= nack_nxt;
		end
	end

	always_comb begin
		lock_nxt = lock_r;
		oper_nxt = oper_r;
		onoff_nxt = onoff_r;
		vout_nxt = vout_r;
		mask_nxt = mask_r;
		nv_nxt = nv_r;
		cnt_nxt = (cnt_r != '0) ? cnt_r - BW'(1) : cnt_r;
		set_v = '0;
		clear_v = 1'b0;
		store_p = 1'b0;
		restore_p = 1'b0;
		nack_set = 1'b0;
		// refused commits fall through with nothing changed
		if (commit && wr_ok(cmd_r, lock_r)) begin
			case (cmd_r)
			CMD_WRITE_LOCK: if (byte_r == 2'h2) begin
				lock_nxt = d_r[0] & LOCK_FIELD_MASK;
				if (!lock_valid(d_r[0]))
					set_v[IDX_WORD] = STAT_BYTE_CML;
			end
			CMD_OPERATION: if (byte_r == 2'h2)
				oper_nxt = d_r[0];
			CMD_ON_OFF: if (byte_r == 2'h2)
				onoff_nxt = d_r[0];
			CMD_VOUT: if (byte_r == 2'h3)
				vout_nxt = {d_r[1], d_r[0]};
			CMD_CLEAR: if (byte_r == 2'h1)
				clear_v = 1'b1;
			CMD_STORE: if (byte_r == 2'h1) begin
				nv_nxt = NV_STORE;
				store_p = 1'b1;
				cnt_nxt = BW'(BUSY_CYC);
			end
			CMD_RESTORE: if (byte_r == 2'h1) begin
				nv_nxt = NV_RESTORE;
				restore_p = 1'b1;
				cnt_nxt = BW'(BUSY_CYC);
			end
			CMD_ALERT_MASK: if (byte_r == 2'h3) begin
				if (code_ok(d_r[0])) begin
					mask_nxt[code_idx(d_r[0])] = d_r[1];
				end else begin
					set_v[IDX_WORD] = STAT_BYTE_CML;
					set_v[IDX_CML] = CML_IVD;
				end
			end
			default: ;
			endcase
		end
		case (nv_r)
		NV_BOOT: begin
			restore_p = 1'b1;
			nv_nxt = NV_RESTORE;
		end
		NV_IDLE: ;
		NV_STORE: if (i_nvm_done) begin
			nv_nxt = NV_IDLE;
			if (i_nvm_fail) begin
				set_v[IDX_WORD] = STAT_BYTE_CML;
				set_v[IDX_CML] = CML_MEM;
				nack_set = 1'b1;
			end
		end
		NV_RESTORE: if (i_nvm_done) begin
			nv_nxt = NV_IDLE;
			if (i_nvm_fail) begin
				set_v[IDX_WORD] = STAT_BYTE_CML;
				set_v[IDX_CML] = CML_MEM;
			end else begin
				// protection judged with the lock level in force now
				lock_nxt = i_nvm_image.lock & LOCK_FIELD_MASK;
				mask_nxt = i_nvm_image.mask;
				if (wr_ok(CMD_OPERATION, lock_r))
					oper_nxt = i_nvm_image.oper;
				if (wr_ok(CMD_ON_OFF, lock_r))
					onoff_nxt = i_nvm_image.on_off;
				if (wr_ok(CMD_VOUT, lock_r))
					vout_nxt = i_nvm_image.vout;
			end
		end
		default: nv_nxt = NV_IDLE;
		endcase
		// a fault that is still present wins over the clear
		for (int i = 0; i < NSTAT; i++) begin
			stat_nxt[i] = (clear_v ? 8'h00 : stat_r[i]) | set_v[i]
				| (nv_r == NV_STORE ? 8'h00 : i_fault_src[i]);
		end
		alert_nxt = 1'b0;
		for (int i = 0; i < NSTAT; i++)
			alert_nxt = alert_nxt | (|(stat_r[i] & ~mask_r[i]));
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lock_r <= 8'h00;
			oper_r <= OPER_RESET;
			onoff_r <= ON_OFF_RESET;
			vout_r <= VOUT_RESET;
			mask_r <= '0;
			stat_r <= '0;
			nv_r <= NV_BOOT;
			cnt_r <= '0;
			alert_r <= 1'b0;
		end else begin
			lock_r <= lock_nxt;
			oper_r <= oper_nxt;
			onoff_r <= onoff_nxt;
			vout_r <= vout_nxt;
			mask_r <= mask_nxt;
			stat_r <= stat_nxt;
			nv_r <= nv_nxt;
			cnt_r <= cnt_nxt;
			alert_r <= alert_nxt;
		end
	end

	assign o_settings = '{lock: lock_r, oper: oper_r, on_off: onoff_r,
		vout: vout_r, mask: mask_r};
	assign o_nvm_image = o_settings;
	assign o_nvm_store = store_p;
	assign o_nvm_restore = restore_p;
	assign o_fault_ignore = (nv_r == NV_STORE);
	assign o_switch_stop = (nv_r == NV_RESTORE);
	assign o_sda_out = 1'b0;
	assign o_sda_oe = oe_r;
	assign o_smbalert_out = 1'b0;
	assign o_smbalert_oe = alert_r;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_reset_n);

	AST_LOCK_ALL: assert property (commit && lock_r == LOCK_ALL
		&& cmd_r == CMD_OPERATION |=> $stable(oper_r))
		else $error("operation written under lock-all");
	AST_LOCK_OPER: assert property (commit && lock_r == LOCK_OPER
		&& cmd_r == CMD_ON_OFF |=> $stable(onoff_r))
		else $error("on/off written under operation lock");
	AST_LOCK_CTRL: assert property (commit && lock_r == LOCK_CTRL
		&& cmd_r == CMD_VOUT && byte_r == 2'h3 && nv_r == NV_IDLE
		|=> vout_r == $past({d_r[1], d_r[0]}))
		else $error("vout write refused under control lock");
	AST_BAD_LOCK: assert property (commit && cmd_r == CMD_WRITE_LOCK
		&& byte_r == 2'h2 && !lock_valid(d_r[0])
		|=> (stat_r[IDX_WORD] & STAT_BYTE_CML) != 8'h00)
		else $error("multiple lock bits did not flag cml");
	AST_LOCK_LOW: assert property ((lock_r & ~LOCK_FIELD_MASK) == 8'h00)
		else $error("low lock bits not zero");
	AST_BUSY: assert property (o_nvm_store |=> busy [*8] ##1 busy)
		else $error("bus not held busy after store");
	AST_STORE_IGN: assert property (nv_r == NV_STORE && !commit
		&& !i_nvm_done |=> stat_r == $past(stat_r))
		else $error("fault latched during store");
	AST_CLEAR: assert property (commit && cmd_r == CMD_CLEAR
		&& byte_r == 2'h1 && wr_ok(CMD_CLEAR, lock_r)
		&& i_fault_src == '0 && nv_r == NV_IDLE
		|=> stat_r == '0 ##1 !o_smbalert_oe)
		else $error("clear faults did not clear status and alert");
	AST_MEM_FAIL: assert property (nv_r == NV_STORE && i_nvm_done
		&& i_nvm_fail |=> nack_r && (stat_r[IDX_CML] & CML_MEM) != 8'h00)
		else $error("programming failure not reported");
	AST_RESTORE_WP: assert property (nv_r == NV_RESTORE && i_nvm_done
		&& lock_r == LOCK_ALL |=> $stable(oper_r) && $stable(vout_r))
		else $error("restore overwrote protected register");
	AST_RESTORE_ALL: assert property (nv_r == NV_RESTORE && i_nvm_done
		&& !i_nvm_fail && (!lock_valid(lock_r) || lock_r == 8'h00)
		|=> oper_r == $past(i_nvm_image.oper)
		&& vout_r == $past(i_nvm_image.vout))
		else $error("restore did not reload unprotected registers");
endmodule

// >>> testbench/pwlnc_host.sv
`timescale 1ns/100ps
module pwlnc_host #(
	parameter logic [6:0] ADDR = 7'h10
) (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic tk(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// data moves only while scl is low, sampled late in the high phase
	task automatic bit_x(input logic b, output logic r);
		o_scl = 1'b0;
		tk(2);
		o_sda_low = ~b;
		tk(2);
		o_scl = 1'b1;
		tk(3);
		r = i_sda;
		tk(1);
	endtask
	// serves repeated start too: sda is let go only while scl is low
	task automatic start;
		o_scl = 1'b0;
		tk(2);
		o_sda_low = 1'b0;
		tk(2);
		o_scl = 1'b1;
		tk(2);
		o_sda_low = 1'b1;
		tk(2);
	endtask
	task automatic stop;
		o_scl = 1'b0;
		tk(2);
		o_sda_low = 1'b1;
		tk(2);
		o_scl = 1'b1;
		tk(2);
		o_sda_low = 1'b0;
		tk(4);
	endtask
	task automatic byte_w(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(v[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask
	// the last byte read gets a nack so the device lets go of sda
	task automatic byte_r(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, v[i]);
		bit_x(last, r);
	endtask
	task automatic xfer(input logic [7:0] c, input int nw, input int d,
			input int nr, output logic [15:0] rd, output logic ack);
		logic a;
		rd = '0;
		start();
		byte_w({ADDR, 1'b0}, ack);
		// a refused address ends the frame; no answer is awaited
		if (ack) begin
			byte_w(c, a);
			for (int i = 0; i < nw; i++)
				byte_w(d[8*i +: 8], a);
			if (nr > 0) begin
				start();
				byte_w({ADDR, 1'b1}, a);
				for (int i = 0; i < nr; i++)
					byte_r(i == nr - 1, rd[8*i +: 8]);
			end
		end
		stop();
	endtask
endmodule

// >>> testbench/pwlnc_core_tb.sv
`timescale 1ns/100ps
module pwlnc_core_tb
	import pwlnc_pkg::*;
;
	localparam int BUSY = 300;
	logic                  mclk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  scl;
	logic                  sda_low;
	logic                  sda_oe;
	logic                  alert_protocol_supported;
	logic                  st_p;
	logic                  rs_p;
	logic                  f_ign;
	logic                  sw_stop;
	logic                  nv_done = 1'b0;
	logic                  nv_fail = 1'b0;
	logic                  fail_en = 1'b0;
	logic                  ack;
	logic                  sda_o;
	logic                  al_o;
	logic [15:0]           rd;
	logic [NSTAT-1:0][7:0] fault = '0;
	pwlnc_image_t          ee = '{8'h00, OPER_RESET, ON_OFF_RESET,
		VOUT_RESET, '0};
	pwlnc_image_t          img;
	pwlnc_image_t          set;
	int                    fail_count = 0;
	int                    num_checks = 0;
	int                    nv_cnt = 0;
	int                    m_lock, m_oper, m_on, m_vout, s_oper, s_vout;
	int                    lv[$] = '{8'h00, 8'h20, 8'h40, 8'h80};
	wire                   sda = ~(sda_low | sda_oe);

	always #20 mclk = ~mclk;

	pwlnc_core #(.SLAVE_ADDR(7'h10), .BUSY_CYC(BUSY)) i_dut (
		.i_mclk(mclk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda),
		.i_fault_src(fault), .i_nvm_done(nv_done), .i_nvm_fail(nv_fail),
		.i_nvm_image(ee), .o_sda_out(sda_o), .o_sda_oe(sda_oe),
		.o_smbalert_out(al_o), .o_smbalert_oe(alert_protocol_supported), .o_nvm_store(st_p),
		.o_nvm_restore(rs_p), .o_nvm_image(img), .o_fault_ignore(f_ign),
		.o_switch_stop(sw_stop), .o_settings(set));
	pwlnc_host #(.ADDR(7'h10)) i_host (.i_clk(mclk), .i_sda(sda),
		.o_scl(scl), .o_sda_low(sda_low));

	// memory answers 20 cycles after each request, faster than a byte
	always @(negedge mclk) begin
		if (st_p)
			ee <= img;
		if (st_p | rs_p)
			nv_cnt <= 20;
		else if (nv_cnt > 0)
			nv_cnt <= nv_cnt - 1;
		nv_done <= nv_cnt == 1;
		nv_fail <= fail_en;
	end

	task automatic wrap_up;
		if (fail_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] seen,
			input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	function automatic bit allowed(input logic [7:0] c);
		int lk;
		lk = m_lock & 8'hE0;
		if ($countones(lk) != 1 || c == CMD_WRITE_LOCK)
			return 1;
		if (lk == 8'h80)
			return 0;
		if (c == CMD_OPERATION)
			return 1;
		return lk == 8'h20 && (c == CMD_ON_OFF || c == CMD_VOUT);
	endfunction
	task automatic op(input logic [7:0] c, input int nw, input int d,
			input int nr);
		bit ok;
		ok = allowed(c);
		i_host.xfer(c, nw, d, nr, rd, ack);
		repeat (4) @(negedge mclk);
		if (ok && ack && nw > 0 && nr == 0)
			case (c)
				CMD_WRITE_LOCK: m_lock = d & 8'hE0;
				CMD_OPERATION: m_oper = d;
				CMD_ON_OFF: m_on = d;
				CMD_VOUT: m_vout = d;
				default: ;
			endcase
		chk("lock", set.lock, m_lock);
		chk("oper", set.oper, m_oper);
		chk("on_off", set.on_off, m_on);
		chk("vout", set.vout, m_vout);
	endtask

	initial begin
		void'($urandom(32'h993a_790b));
		m_lock = 0;
		m_oper = OPER_RESET;
		m_on = ON_OFF_RESET;
		m_vout = VOUT_RESET;
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		repeat (40) @(negedge mclk);
		op(CMD_FEATURES, 0, 0, 1);
		chk("features", rd, 16'h00B0);
		foreach (lv[k]) begin
			op(CMD_WRITE_LOCK, 1, lv[k] | ($urandom & 8'h1F), 0);
			op(CMD_WRITE_LOCK, 0, 0, 1);
			chk("lock_rd", rd, lv[k]);
			op(CMD_OPERATION, 1, m_oper ^ 8'h80, 0);
			op(CMD_ON_OFF, 1, m_on ^ 8'h08, 0);
			op(CMD_VOUT, 2, $urandom % 2816, 0);
			op(CMD_VOUT, 0, 0, 2);
			chk("vout_rd", rd, m_vout);
			op(CMD_OPERATION, 0, 0, 1);
			chk("oper_rd", rd, m_oper);
			op(CMD_ON_OFF, 0, 0, 1);
			chk("on_rd", rd, m_on);
		end
		op(CMD_RESTORE, 0, 0, 0);
		chk("no_restore", sw_stop, 1'b0);
		op(CMD_WRITE_LOCK, 1, 8'hE0, 0);
		chk("lock_ack", ack, 1'b1);
		chk("alert_set", alert_protocol_supported, 1'b1);
		chk("od_lvl", {sda_o, al_o}, 2'b00);
		op(CMD_OPERATION, 1, m_oper ^ 8'h80, 0);
		op(CMD_STAT_BYTE, 0, 0, 1);
		chk("cml_set", rd & STAT_BYTE_CML, STAT_BYTE_CML);
		op(CMD_CLEAR, 0, 0, 0);
		chk("alert_clr", alert_protocol_supported, 1'b0);
		op(CMD_ALERT_MASK, 2, {STAT_BYTE_CML, CMD_STAT_WORD}, 0);
		op(CMD_WRITE_LOCK, 1, 8'hC0, 0);
		chk("alert_mask", alert_protocol_supported, 1'b0);
		op(CMD_ALERT_MASK, 1, CMD_STAT_WORD, 2);
		chk("mask_rd", rd, {STAT_BYTE_CML, BLOCK_COUNT_ONE});
		s_oper = m_oper;
		s_vout = m_vout;
		op(CMD_STORE, 0, 0, 0);
		chk("fault_ign", f_ign, 1'b1);
		op(CMD_OPERATION, 0, 0, 1);
		chk("busy_nack", ack, 1'b0);
		repeat (BUSY) @(negedge mclk);
		chk("ee_lock", ee.lock, m_lock);
		chk("ee_vout", ee.vout, s_vout);
		op(CMD_OPERATION, 1, (m_oper ^ 8'h08) & 8'h7F, 0);
		chk("busy_end", ack, 1'b1);
		op(CMD_VOUT, 2, $urandom % 2816, 0);
		// on bit is clear here, so the restart disturbs no sequencing
		op(CMD_RESTORE, 0, 0, 0);
		chk("sw_stop", sw_stop, 1'b1);
		repeat (BUSY) @(negedge mclk);
		m_oper = s_oper;
		m_vout = s_vout;
		op(CMD_OPERATION, 0, 0, 1);
		chk("oper_back", rd, s_oper);
		fault[1] = 8'h04;
		op(CMD_CLEAR, 0, 0, 0);
		fault[1] = 8'h00;
		op(CMD_STAT_WORD + 8'h01, 0, 0, 1);
		chk("fault_back", rd, 16'h0004);
		op(CMD_ALERT_MASK, 2, {8'hFF, 8'h20}, 0);
		op(CMD_ALERT_MASK, 1, 8'h20, 2);
		chk("mask_bad_rd", rd, {8'h00, BLOCK_COUNT_ONE});
		op(CMD_STAT_CML, 0, 0, 1);
		chk("cml_ivd", rd & CML_IVD, CML_IVD);
		op(CMD_CLEAR, 0, 0, 0);
		fail_en = 1'b1;
		op(CMD_STORE, 0, 0, 0);
		// fault pulse ends well before the memory answers
		fault[2] = 8'h08;
		repeat (10) @(negedge mclk);
		fault[2] = 8'h00;
		repeat (BUSY) @(negedge mclk);
		fail_en = 1'b0;
		op(CMD_STAT_BYTE, 0, 0, 1);
		chk("fail_nack", ack, 1'b0);
		op(CMD_STAT_CML, 0, 0, 1);
		chk("cml_mem", rd & CML_MEM, CML_MEM);
		op(CMD_STAT_BYTE, 0, 0, 1);
		chk("cml_byte", rd & STAT_BYTE_CML, STAT_BYTE_CML);
		op(CMD_STAT_WORD + 8'h02, 0, 0, 1);
		chk("store_ign", rd, 16'h0000);
		wrap_up();
	end

	// about four times the expected run
	initial begin
		#3_000_000;
		fail_count++;
		wrap_up();
	end
endmodule
